// ===== logic/rcf_pkg.sv
// constants, register map and bus carriers for the reset start-up block
// assumes a 50 MHz aclk and an AXI4-Lite master with 8-bit byte addresses
package rcf_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned SLOW_OSC_HZ = 31_000;
  localparam int unsigned SLOW_DIV = CLK_HZ / SLOW_OSC_HZ;
  localparam logic [10:0] SLOW_DIV_LAST = 11'(SLOW_DIV - 1);
  localparam int unsigned PIN_DLY_CYC = 10;
  localparam logic [3:0] PIN_DLY_LAST = 4'(PIN_DLY_CYC);

  localparam logic [7:0] ADDR_FLAGS = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_ST = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;

  localparam int unsigned B_STACK_OVERFLOW_FLAG = 7;
  localparam int unsigned B_STACK_UNDERFLOW_FLAG = 6;
  localparam int unsigned B_START = 5;
  localparam int unsigned B_WDT = 4;
  localparam int unsigned B_PIN = 3;
  localparam int unsigned B_RI = 2;
  localparam int unsigned B_POR = 1;
  localparam int unsigned B_BOR = 0;
  localparam logic [7:0] FLAGS_RST = 8'h1C;
  localparam logic [7:0] FLAGS_WMASK = 8'hDF;
  localparam logic [7:0] POR_MASK = 8'h02;

  localparam int unsigned C_POWER_UP_TIMER_EN = 0;
  localparam int unsigned C_PIN_EN = 1;
  localparam int unsigned C_OST_EN = 2;
  localparam logic [2:0] CTRL_RST = 3'h7;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } rcf_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rcf_axi_rsp_t;

  typedef enum logic {
    ST_HOLD = 1'b0,
    ST_RUN = 1'b1
  } rcf_state_t;
endpackage : rcf_pkg

// ===== logic/rcf_reset_start.sv
// start-up gating after power-on or brown-out, reset-cause flags,
// interrupt status and an AXI4-Lite register slave.
// assumes all event inputs are one-cycle pulses synchronous to aclk.
//
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module rcf_reset_start #(
  parameter int unsigned POWER_UP_TIMER_TICKS = 2048,
  parameter int unsigned OST_CYCLES = 1024
)(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic por_event,
  input wire logic bor_event,
  input wire logic master_clear_pin,
  input wire logic wdt_reset,
  input wire logic reset_instr,
  input wire logic stack_ovf,
  input wire logic stack_unf,
  input wire rcf_pkg::rcf_axi_req_t axi_req,
  output rcf_pkg::rcf_axi_rsp_t axi_rsp,
  output logic core_run,
  output logic slow_osc_tick,
  output logic irq
);
  import rcf_pkg::*;

  localparam logic [15:0] POWER_UP_TIMER_LAST = 16'(POWER_UP_TIMER_TICKS);
  localparam logic [15:0] OST_LAST = 16'(OST_CYCLES);

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == ADDR_FLAGS) || (a == ADDR_CTRL) ||
                (a == ADDR_STAT) || (a == ADDR_IRQ_ST) ||
                (a == ADDR_IRQ_MASK);
  endfunction : is_mapped

  // registers
  logic [10:0] div_q;
  logic [10:0] div_d;
  logic tick_q;
  logic [15:0] power_up_timer_q;
  logic [15:0] power_up_timer_d;
  logic [15:0] ost_q;
  logic [15:0] ost_d;
  logic [3:0] pin_q;
  logic [3:0] pin_d;
  logic pin_prev_q;
  rcf_state_t state_q;
  rcf_state_t state_d;
  logic [7:0] flags_q;
  logic [7:0] flags_d;
  logic [2:0] ctrl_q;
  logic [2:0] ctrl_d;
  logic [7:0] ist_q;
  logic [7:0] ist_d;
  logic [7:0] imask_q;
  logic [7:0] imask_d;
  logic irq_q;

  // bus slave registers
  logic aw_hold_q;
  logic [7:0] aw_addr_q;
  logic w_hold_q;
  logic [31:0] w_data_q;
  logic w_lane0_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // named wires
  logic restart;
  logic div_wrap;
  logic power_up_timer_done;
  logic ost_done;
  logic pin_ok;
  logic pin_hold;
  logic pin_rst_ev;
  logic start_ready;
  logic run_start;
  logic awready;
  logic wready;
  logic arready;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic commit;
  logic wr_ok;
  logic wr_flags;
  logic wr_ctrl;
  logic wr_ist;
  logic wr_imask;
  logic [7:0] wbyte;
  logic [7:0] events;
  logic [31:0] rd_mux;

  assign restart = por_event | bor_event;

  // slow oscillator derived from aclk; ticks feed power-up timer and watchdog
  assign div_wrap = div_q == SLOW_DIV_LAST;
  assign div_d = div_wrap ? 11'h000 : div_q + 11'h001;

  // timers restart only on power-on or brown-out, never on the pin
  assign power_up_timer_d = restart ? 16'h0000 :
                  (tick_q && power_up_timer_q != POWER_UP_TIMER_LAST) ? power_up_timer_q + 16'h0001 :
                  power_up_timer_q;
  assign ost_d = restart ? 16'h0000 :
                 (ost_q != OST_LAST) ? ost_q + 16'h0001 :
                 ost_q;
  assign power_up_timer_done = !ctrl_q[C_POWER_UP_TIMER_EN] || power_up_timer_q == POWER_UP_TIMER_LAST;
  assign ost_done = !ctrl_q[C_OST_EN] || ost_q == OST_LAST;

  // released-pin counter saturates, so a pin released long ago adds no delay
  assign pin_d = !master_clear_pin ? 4'h0 :
                 (pin_q != PIN_DLY_LAST) ? pin_q + 4'h1 :
                 pin_q;
  // the live pin level gates too, so a pin that drops on the edge the count
  // completes can never let the core start while it is held in reset
  assign pin_ok = !ctrl_q[C_PIN_EN] ||
                  (master_clear_pin && pin_q == PIN_DLY_LAST);
  assign pin_hold = ctrl_q[C_PIN_EN] && !master_clear_pin;
  assign pin_rst_ev = ctrl_q[C_PIN_EN] && pin_prev_q && !master_clear_pin;

  assign start_ready = power_up_timer_done && ost_done && pin_ok;

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_HOLD:
      begin
        if (start_ready && !restart)
        begin
          state_d = ST_RUN;
        end
      end
      ST_RUN:
      begin
        if (restart || pin_hold)
        begin
          state_d = ST_HOLD;
        end
      end
    endcase
  end

  assign run_start = state_q == ST_HOLD && state_d == ST_RUN;

  // AXI4-Lite handshakes; everything stalls while clk_en is low
  assign awready = clk_en && !aw_hold_q && !bvalid_q;
  assign wready = clk_en && !w_hold_q && !bvalid_q;
  assign arready = clk_en && !rvalid_q;
  assign aw_take = axi_req.awvalid && awready;
  assign w_take = axi_req.wvalid && wready;
  assign ar_take = axi_req.arvalid && arready;
  assign commit = clk_en && aw_hold_q && w_hold_q && !bvalid_q;
  assign wr_ok = commit && is_mapped(aw_addr_q) && w_lane0_q;
  assign wbyte = w_data_q[7:0];
  assign wr_flags = wr_ok && aw_addr_q == ADDR_FLAGS;
  assign wr_ctrl = wr_ok && aw_addr_q == ADDR_CTRL;
  assign wr_ist = wr_ok && aw_addr_q == ADDR_IRQ_ST;
  assign wr_imask = wr_ok && aw_addr_q == ADDR_IRQ_MASK;

  // firmware write first, then hardware events, so hardware always wins
  always_comb
  begin
    flags_d = flags_q;
    if (wr_flags)
    begin
      flags_d = wbyte & FLAGS_WMASK;
    end
    if (restart)
    begin
      flags_d = (FLAGS_RST & ~POR_MASK) | (flags_d & POR_MASK);
    end
    if (por_event)
    begin
      flags_d[B_POR] = 1'b0;
    end
    if (restart)
    begin
      flags_d[B_BOR] = 1'b0;
    end
    if (stack_ovf)
    begin
      flags_d[B_STACK_OVERFLOW_FLAG] = 1'b1;
    end
    if (stack_unf)
    begin
      flags_d[B_STACK_UNDERFLOW_FLAG] = 1'b1;
    end
    if (wdt_reset)
    begin
      flags_d[B_WDT] = 1'b0;
    end
    if (pin_rst_ev)
    begin
      flags_d[B_PIN] = 1'b0;
    end
    if (reset_instr)
    begin
      flags_d[B_RI] = 1'b0;
    end
  end

  assign ctrl_d = wr_ctrl ? wbyte[2:0] : ctrl_q;

  // interrupt status shares the flag layout; bit 5 marks start of execution
  assign events = {stack_ovf, stack_unf, run_start, wdt_reset,
                   pin_rst_ev, reset_instr, por_event, bor_event};
  assign ist_d = ((wr_ist ? ist_q & ~wbyte : ist_q)) | events;
  assign imask_d = wr_imask ? wbyte : imask_q;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (axi_req.araddr)
      ADDR_FLAGS: rd_mux[7:0] = flags_q;
      ADDR_CTRL: rd_mux[2:0] = ctrl_q;
      ADDR_STAT: rd_mux[4:0] = {pin_ok, master_clear_pin, ost_done,
                                power_up_timer_done, state_q == ST_RUN};
      ADDR_IRQ_ST: rd_mux[7:0] = ist_q;
      ADDR_IRQ_MASK: rd_mux[7:0] = imask_q;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // start-up and flag state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      div_q <= 11'h000;
      tick_q <= 1'b0;
      power_up_timer_q <= 16'h0000;
      ost_q <= 16'h0000;
      pin_q <= 4'h0;
      pin_prev_q <= 1'b0;
      state_q <= ST_HOLD;
      flags_q <= FLAGS_RST;
      ctrl_q <= CTRL_RST;
    end
    else if (clk_en)
    begin
      div_q <= div_d;
      tick_q <= div_wrap;
      power_up_timer_q <= power_up_timer_d;
      ost_q <= ost_d;
      pin_q <= pin_d;
      pin_prev_q <= master_clear_pin;
      state_q <= state_d;
      flags_q <= flags_d;
      ctrl_q <= ctrl_d;
    end
  end

  // interrupt state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ist_q <= 8'h00;
      imask_q <= 8'h00;
      irq_q <= 1'b0;
    end
    else if (clk_en)
    begin
      ist_q <= ist_d;
      imask_q <= imask_d;
      irq_q <= |(ist_d & imask_d);
    end
  end

  // write channel capture and response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_hold_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_lane0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end
    else if (clk_en)
    begin
      if (aw_take)
      begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= axi_req.awaddr;
      end
      if (w_take)
      begin
        w_hold_q <= 1'b1;
        w_data_q <= axi_req.wdata;
        w_lane0_q <= axi_req.wstrb[0];
      end
      if (commit)
      begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= is_mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_q && axi_req.bready)
      begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // read channel; a read has no side effect
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end
    else if (clk_en)
    begin
      if (ar_take)
      begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_mux;
        rresp_q <= is_mapped(axi_req.araddr) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rvalid_q && axi_req.rready)
      begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign axi_rsp.awready = awready;
  assign axi_rsp.wready = wready;
  assign axi_rsp.bvalid = bvalid_q;
  assign axi_rsp.bresp = bresp_q;
  assign axi_rsp.arready = arready;
  assign axi_rsp.rvalid = rvalid_q;
  assign axi_rsp.rdata = rdata_q;
  assign axi_rsp.rresp = rresp_q;
  assign core_run = state_q == ST_RUN;
  assign slow_osc_tick = tick_q;
  assign irq = irq_q;
endmodule : rcf_reset_start

// ===== testbench/rcf_monitor.sv
// port checker for the reset start-up block
// bound to every rcf_reset_start instance, single aclk domain
`timescale 1ns/1ps
module rcf_monitor
  import rcf_pkg::*;
#(
  parameter int unsigned POWER_UP_TIMER_TICKS = 2048,
  parameter int unsigned OST_CYCLES = 1024
)(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic por_event,
  input wire logic bor_event,
  input wire logic master_clear_pin,
  input wire logic wdt_reset,
  input wire logic reset_instr,
  input wire logic stack_ovf,
  input wire logic stack_unf,
  input wire rcf_pkg::rcf_axi_req_t axi_req,
  input wire rcf_pkg::rcf_axi_rsp_t axi_rsp,
  input wire logic core_run,
  input wire logic slow_osc_tick,
  input wire logic irq
);
  // cycles the pin has been high, and cycles since the last slow tick
  logic [3:0] hi_q;
  logic [10:0] gap_q;
  logic seen_q;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !master_clear_pin)
      hi_q <= 4'h0;
    else if (hi_q != 4'hF)
      hi_q <= hi_q + 4'h1;
    if (!aresetn)
      seen_q <= 1'b0;
    else if (clk_en && slow_osc_tick)
      seen_q <= 1'b1;
    if (clk_en)
      gap_q <= slow_osc_tick ? 11'h0 : gap_q + 11'h1;
  end
  property p_restart;
    clk_en && (por_event || bor_event) |=> !core_run;
  endproperty
  a_restart: assert property (p_restart)
    else $error("run kept after restart");
  property p_pin;
    clk_en && !master_clear_pin |=> !core_run;
  endproperty
  a_pin: assert property (p_pin)
    else $error("run while pin low");
  property p_start;
    $rose(core_run) |-> hi_q >= 4'hB;
  endproperty
  a_start: assert property (p_start)
    else $error("run too soon after pin");
  property p_tick;
    clk_en && slow_osc_tick && seen_q |-> gap_q == SLOW_DIV_LAST;
  endproperty
  a_tick: assert property (p_tick)
    else $error("slow tick spacing");
  property p_rd;
    clk_en && axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid;
  endproperty
  a_rd: assert property (p_rd)
    else $error("read answer late");
  property p_wr;
    clk_en && axi_req.awvalid && axi_rsp.awready && axi_req.wvalid
      && axi_rsp.wready |=> !axi_rsp.bvalid ##1 axi_rsp.bvalid;
  endproperty
  a_wr: assert property (p_wr)
    else $error("write answer timing");
  property p_bhold;
    axi_rsp.bvalid && !axi_req.bready |=>
      axi_rsp.bvalid && $stable(axi_rsp.bresp);
  endproperty
  a_bhold: assert property (p_bhold)
    else $error("write answer dropped");
  property p_rhold;
    axi_rsp.rvalid && !axi_req.rready |=>
      axi_rsp.rvalid && $stable(axi_rsp.rdata);
  endproperty
  a_rhold: assert property (p_rhold)
    else $error("read answer dropped");
  property p_aw_ref;
    axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready;
  endproperty
  a_aw_ref: assert property (p_aw_ref)
    else $error("write taken while answer pending");
  property p_clken;
    !clk_en |-> !axi_rsp.awready && !axi_rsp.arready;
  endproperty
  a_clken: assert property (p_clken)
    else $error("ready while frozen");
endmodule : rcf_monitor

bind rcf_reset_start rcf_monitor #(
  .POWER_UP_TIMER_TICKS(POWER_UP_TIMER_TICKS),
  .OST_CYCLES(OST_CYCLES)
) u_mon (.aclk, .aresetn, .clk_en, .por_event, .bor_event,
  .master_clear_pin, .wdt_reset, .reset_instr, .stack_ovf, .stack_unf,
  .axi_req, .axi_rsp, .core_run, .slow_osc_tick, .irq);

// ===== testbench/rcf_reset_start_tb.sv
// self-checking bench for the reset start-up block
// short timer counts keep the run near 6500 cycles
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value at %0t got %h exp %h", $time, g, e); end end
module rcf_reset_start_tb;
  import rcf_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic clk_en = 1'b1;
  logic master_clear_pin = 1'b0;
  // event pulses by index, so one task can pulse any of them
  localparam int unsigned E_OVF = 0, E_UNF = 1, E_RI = 2;
  localparam int unsigned E_WDT = 3, E_BOR = 4, E_POR = 5;
  logic [5:0] ev = 6'h00;
  wire stack_ovf = ev[E_OVF];
  wire stack_unf = ev[E_UNF];
  wire reset_instr = ev[E_RI];
  wire wdt_reset = ev[E_WDT];
  wire bor_event = ev[E_BOR];
  wire por_event = ev[E_POR];
  logic core_run, slow_osc_tick, irq;
  rcf_axi_req_t req = '0;
  rcf_axi_rsp_t rsp;
  int fail_count = 0, tests_run = 0, n;
  always #10 aclk = ~aclk;
  rcf_reset_start #(.POWER_UP_TIMER_TICKS(2), .OST_CYCLES(20)) dut (.aclk, .aresetn,
    .clk_en, .por_event, .bor_event, .master_clear_pin, .wdt_reset,
    .reset_instr, .stack_ovf, .stack_unf, .axi_req(req), .axi_rsp(rsp),
    .core_run, .slow_osc_tick, .irq);
  task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] er = 2'h0);
    logic ta, tw;
    ta = 0;
    tw = 0;
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    while (!(ta && tw))
    begin
      @(posedge aclk);
      if (rsp.awready && !ta)
      begin
        ta = 1;
        req.awvalid <= 1'b0;
      end
      if (rsp.wready && !tw)
      begin
        tw = 1;
        req.wvalid <= 1'b0;
      end
    end
    // late ready so the answer is seen to wait
    repeat (2) @(posedge aclk);
    req.bready <= 1'b1;
    do @(posedge aclk); while (!rsp.bvalid);
    req.bready <= 1'b0;
    `CHK(rsp.bresp, er)
  endtask : wr
  task automatic rd(logic [7:0] a, logic [31:0] ed, logic [1:0] er = 2'h0);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    do @(posedge aclk); while (!rsp.arready);
    req.arvalid <= 1'b0;
    @(posedge aclk);
    req.rready <= 1'b1;
    do @(posedge aclk); while (!rsp.rvalid);
    req.rready <= 1'b0;
    `CHK(rsp.rdata, ed)
    `CHK(rsp.rresp, er)
  endtask : rd
  task automatic pl(input int unsigned k);
    ev[k] <= 1'b1;
    @(posedge aclk);
    ev[k] <= 1'b0;
    @(posedge aclk);
  endtask : pl
  task automatic rise11;
    master_clear_pin <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      #1;
      n++;
    end
    while (!core_run && n < 40);
    `CHK(n, 11)
  endtask : rise11
  task results;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  // about three times the expected run length
  initial
  begin
    #400000;
    fail_count++;
    results;
  end
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_FLAGS, 32'h1C);
    rd(ADDR_CTRL, 32'h7);
    repeat (4000) @(posedge aclk);
    `CHK(core_run, 1'b0)
    rd(ADDR_STAT, 32'h06);
    rise11;
    master_clear_pin <= 1'b0;
    @(posedge aclk);
    #1;
    `CHK(core_run, 1'b0)
    rd(ADDR_FLAGS, 32'h14);
    rise11;
    wr(ADDR_FLAGS, 32'hFF);
    rd(ADDR_FLAGS, 32'hDF);
    wr(ADDR_FLAGS, 32'h1F);
    pl(E_OVF);
    rd(ADDR_FLAGS, 32'h9F);
    pl(E_UNF);
    rd(ADDR_FLAGS, 32'hDF);
    pl(E_RI);
    rd(ADDR_FLAGS, 32'hDB);
    pl(E_WDT);
    rd(ADDR_FLAGS, 32'hCB);
    `CHK(irq, 1'b0)
    wr(ADDR_IRQ_MASK, 32'h80);
    @(posedge aclk);
    #1;
    `CHK(irq, 1'b1)
    wr(ADDR_IRQ_ST, 32'hFF);
    @(posedge aclk);
    #1;
    `CHK(irq, 1'b0)
    rd(ADDR_IRQ_ST, 32'h0);
    pl(E_OVF);
    #1;
    `CHK(irq, 1'b1)
    wr(ADDR_IRQ_MASK, 32'h0);
    @(posedge aclk);
    #1;
    `CHK(irq, 1'b0)
    pl(E_BOR);
    `CHK(core_run, 1'b0)
    rd(ADDR_FLAGS, 32'h1E);
    pl(E_POR);
    rd(ADDR_FLAGS, 32'h1C);
    rd(8'h20, 32'h0, RESP_SLVERR);
    wr(8'h20, 32'h1, RESP_SLVERR);
    n = 0;
    while (!core_run && n < 6000)
    begin
      @(posedge aclk);
      n++;
    end
    `CHK(core_run, 1'b1)
    // only the pin stays enabled, so a restart runs again at once
    wr(ADDR_CTRL, 32'h2);
    pl(E_POR);
    rd(ADDR_STAT, 32'h1F);
    rd(ADDR_CTRL, 32'h2);
    // a pulse while frozen must leave no mark
    clk_en <= 1'b0;
    pl(E_OVF);
    clk_en <= 1'b1;
    rd(ADDR_FLAGS, 32'h1C);
    `CHK(core_run, 1'b1)
    aresetn <= 1'b0;
    @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_FLAGS, 32'h1C);
    rd(ADDR_CTRL, 32'h7);
    results;
  end
endmodule : rcf_reset_start_tb
